//--- dv/lpms_core_model.sv
`timescale 1ns/1ps
// Processor and wake-source stand-in; past its time-zero levels it drives only at rising edges.
module lpms_core_model
	import lpms_pkg::*;
(
	// Clock.
	input wire logic clk_i,
	// Toward the sequencer.
	output lpms_core_s core_o,
	output lpms_wake_s wake_o
);
	// Quiet levels at time zero; the force pin idles high.
	initial begin
		core_o = '0;
		wake_o = '0;
		wake_o.force_wake_pin_b = 1'b1;
	end

	// Deep-sleep bit is a level; the instruction is a one-cycle pulse.
	task automatic instr(input logic evt, input logic deep);
		@(posedge clk_i);
		core_o.deep_sleep_select <= deep;
		if (!deep) begin
			repeat (3) @(posedge clk_i);
		end
		core_o.wait_for_event_instr <= evt;
		core_o.wait_for_interrupt_instr <= !evt;
		@(posedge clk_i);
		core_o.wait_for_event_instr <= 1'b0;
		core_o.wait_for_interrupt_instr <= 1'b0;
	endtask

	// Interrupt and event levels as the core would present them.
	task automatic levels(input logic irq, input logic evt);
		@(posedge clk_i);
		core_o.irq <= irq;
		core_o.event_in <= evt;
	endtask

	// All wake sources change together on one edge.
	task automatic wake(input lpms_wake_s w);
		@(posedge clk_i);
		wake_o <= w;
	endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
module tb
	import lpms_pkg::*;
;
	// Short restart keeps the backup loop fast; bound stays above it.
	localparam int REG_START = 10;
	localparam int WAKE_MAX = 20;
	localparam logic [31:0] BK_EN [5] = '{32'h0001_0000, 32'h0000_0008,
		32'h0002_0000, 32'h0004_0000, 32'h0008_0000};
	logic clk_i;
	logic rst_b_i;
	lpms_avs_req_s avs_req;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	lpms_core_s core;
	lpms_wake_s wake;
	lpms_pwr_s pwr;
	lpms_wake_s idle;
	lpms_wake_s w;
	logic [31:0] rd;
	int err_total;
	int num_checks;

	lpms_sequencer #(
		.REG_START_CYC_P(REG_START),
		.BACKUP_WAKE_MAX_CYC_P(WAKE_MAX)
	) i_dut (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.avs_req_i(avs_req),
		.avs_readdata_o(avs_readdata),
		.avs_waitrequest_o(avs_waitrequest),
		.core_i(core),
		.wake_i(wake),
		.pwr_o(pwr)
	);

	lpms_core_model i_core (
		.clk_i(clk_i),
		.core_o(core),
		.wake_o(wake)
	);

	// Free-running 20 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic chkw(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkb(input string what, input logic exp, input logic got);
		chkw(what, {31'h0, exp}, {31'h0, got});
	endtask

	// Outputs are looked at one step after the edge has settled.
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// One Avalon access, held until waitrequest is sampled low; a slave
	// that never answers is left to the watchdog.
	task automatic bus(input logic wr, input logic [4:0] addr,
		input logic [31:0] data, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		avs_req.read <= !wr;
		avs_req.write <= wr;
		avs_req.address <= addr;
		avs_req.writedata <= data;
		avs_req.byteenable <= 4'hf;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest !== 1'b0);
		// Seen at the first edge, answered at the second.
		chkw("bus answer cycles", 32'h2, 32'(n));
		q = avs_readdata;
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
	endtask

	// A hung wake shows up as the bound being exceeded.
	task automatic wait_active(input int limit, input string what);
		int n;
		n = 0;
		while (pwr.core_clk_en !== 1'b1 && n <= limit) begin
			tick(1);
			n++;
		end
		chkb(what, 1'b1, n <= limit);
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog sized well past the whole sequence.
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		end_of_test();
	end

	initial begin
		rst_b_i = 1'b0;
		avs_req = '0;
		err_total = 0;
		num_checks = 0;
		idle = '0;
		idle.force_wake_pin_b = 1'b1;
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		tick(1);
		chkb("shutdown after reset", 1'b1, pwr.regulator_shutdown_ctl);
		chkb("core clock after reset", 1'b1, pwr.core_clk_en);
		chkb("keep alive", 1'b1, pwr.keep_alive);
		// Active mode: source and peripheral clocks follow software.
		bus(1'b1, ADDR_CLK_CFG, 32'h0000_a502, rd);
		tick(2);
		chkw("clock source", 32'h2, {30'h0, pwr.main_clk_src});
		chkw("periph clocks", 32'ha5, {24'h0, pwr.periph_clk_en});
		bus(1'b0, ADDR_CLK_CFG, 32'h0, rd);
		chkw("clk cfg readback", 32'h0000_a502, rd);
		bus(1'b0, 5'h14, 32'h0, rd);
		chkw("unmapped read", 32'h0, rd);
		// Interrupt-wait sleep ignores events, wakes on interrupt.
		i_core.instr(1'b0, 1'b0);
		tick(2);
		chkb("sleep core clock", 1'b0, pwr.core_clk_en);
		chkb("sleep mem clock", 1'b1, pwr.mem_clk_en);
		chkw("sleep periph", 32'ha5, {24'h0, pwr.periph_clk_en});
		chkb("sleep shutdown", 1'b1, pwr.regulator_shutdown_ctl);
		i_core.levels(1'b0, 1'b1);
		tick(3);
		chkb("event ignored", 1'b0, pwr.core_clk_en);
		i_core.levels(1'b1, 1'b0);
		tick(2);
		chkb("irq wake", 1'b1, pwr.core_clk_en);
		bus(1'b0, ADDR_STATUS, 32'h0, rd);
		chkb("irq cause", 1'b1, rd[STATUS_CAUSE_LSB + CAUSE_IRQ]);
		i_core.levels(1'b0, 1'b0);
		// Event-wait sleep wakes on a plain event.
		i_core.instr(1'b1, 1'b0);
		tick(2);
		chkb("event sleep", 1'b0, pwr.core_clk_en);
		i_core.levels(1'b0, 1'b1);
		tick(2);
		chkb("event wake", 1'b1, pwr.core_clk_en);
		i_core.levels(1'b0, 1'b0);
		// Wait mode, once per source kind that may end it; pin 0 idles
		// high in the last pass so that its fall is the wake.
		for (int k = 0; k < 4; k++) begin
			// clock source first, then low-power bit, then instruction.
			bus(1'b1, ADDR_CLK_CFG, 32'h0000_a500, rd);
			bus(1'b1, ADDR_FSMR, 32'h1, rd);
			bus(1'b1, ADDR_WAKE_EN,
				(k == 3) ? 32'h1 : 32'h1 << (WAKE_RTC_BIT + k), rd);
			w = idle;
			w.wake_pins[0] = (k == 3);
			i_core.wake(w);
			i_core.instr(1'b1, 1'b0);
			tick(2);
			chkb("wait core clock", 1'b0, pwr.core_clk_en);
			chkb("wait mem clock", 1'b0, pwr.mem_clk_en);
			chkw("wait periph", 32'h0, {24'h0, pwr.periph_clk_en});
			chkb("wait supply", 1'b1, pwr.regulator_shutdown_ctl);
			bus(1'b0, ADDR_STATUS, 32'h0, rd);
			chkw("wait mode", 32'h2, {29'h0, rd[2:0]});
			bus(1'b1, ADDR_CLK_CFG, 32'h0000_a502, rd);
			w = idle;
			case (k)
				0: w.rtc_alarm = 1'b1;
				1: w.tick_counter_alarm = 1'b1;
				2: w.usb_wake = 1'b1;
				default: w.wake_pins[0] = 1'b0;
			endcase
			i_core.wake(w);
			wait_active(WAIT_WAKE_MAX_CYC, "wait restart time");
			chkw("wake on rc", 32'h0, {30'h0, pwr.main_clk_src});
			chkw("periph back", 32'ha5, {24'h0, pwr.periph_clk_en});
			bus(1'b0, ADDR_STATUS, 32'h0, rd);
			chkb("wait cause", 1'b1, rd[STATUS_CAUSE_LSB +
				((k == 3) ? CAUSE_PINS : CAUSE_RTC + k)]);
			i_core.wake(idle);
		end
		bus(1'b1, ADDR_FSMR, 32'h0, rd);
		// Backup mode: force pin, pin change, supply, RTC, tick alarms.
		for (int k = 0; k < 5; k++) begin
			bus(1'b1, ADDR_WAKE_EN, BK_EN[k], rd);
			bus(1'b1, ADDR_DEBOUNCE, (k == 1) ? 32'h2 : 32'h0, rd);
			i_core.instr(1'b1, 1'b1);
			tick(2);
			chkb("backup shutdown", 1'b0, pwr.regulator_shutdown_ctl);
			chkb("backup reset", 1'b0, pwr.core_rst_b);
			chkb("backup pullup", 1'b1, pwr.io_pullup);
			chkb("backup keep alive", 1'b1, pwr.keep_alive);
			w = idle;
			w.wake_pins[5] = 1'b1;
			i_core.wake(w);
			tick(10);
			chkb("disabled pin", 1'b0, pwr.regulator_shutdown_ctl);
			case (k)
				0: w.force_wake_pin_b = 1'b0;
				1: w.wake_pins[3] = 1'b1;
				2: w.supply_monitor_alarm = 1'b1;
				3: w.rtc_alarm = 1'b1;
				default: w.tick_counter_alarm = 1'b1;
			endcase
			i_core.wake(w);
			tick(6);
			chkb("supply back on", 1'b1, pwr.regulator_shutdown_ctl);
			chkb("still in reset", 1'b0, pwr.core_rst_b);
			wait_active(WAKE_MAX - 6, "backup wake time");
			chkb("reset released", 1'b1, pwr.core_rst_b);
			chkw("backup on rc", 32'h0, {30'h0, pwr.main_clk_src});
			bus(1'b0, ADDR_STATUS, 32'h0, rd);
			chkb("backup cause", 1'b1, rd[STATUS_CAUSE_LSB + k]);
			i_core.wake(idle);
			tick(2);
		end
		end_of_test();
	end
endmodule

//--- verilog/lpms_pkg.sv
package lpms_pkg;

	// Register byte addresses on the Avalon-MM slave.
	localparam logic [4:0] ADDR_FSMR = 5'h00;
	localparam logic [4:0] ADDR_WAKE_EN = 5'h04;
	localparam logic [4:0] ADDR_DEBOUNCE = 5'h08;
	localparam logic [4:0] ADDR_CLK_CFG = 5'h0c;
	localparam logic [4:0] ADDR_STATUS = 5'h10;

	// Field positions.
	localparam int FSMR_LPS_BIT = 0;
	localparam int WAKE_FORCE_BIT = 16;
	localparam int WAKE_SUPPLY_BIT = 17;
	localparam int WAKE_RTC_BIT = 18;
	localparam int WAKE_TICK_BIT = 19;
	localparam int WAKE_USB_BIT = 20;
	localparam int CLK_SRC_LSB = 0;
	localparam int PERIPH_EN_LSB = 8;
	localparam int STATUS_CAUSE_LSB = 8;

	// Main clock source codes.
	localparam logic [1:0] CLK_SRC_RC = 2'h0;
	localparam logic [1:0] CLK_SRC_XTAL = 2'h1;
	localparam logic [1:0] CLK_SRC_PLL = 2'h2;

	// Wake cause bits in the status register.
	localparam int CAUSE_FORCE = 0;
	localparam int CAUSE_PINS = 1;
	localparam int CAUSE_SUPPLY = 2;
	localparam int CAUSE_RTC = 3;
	localparam int CAUSE_TICK = 4;
	localparam int CAUSE_USB = 5;
	localparam int CAUSE_IRQ = 6;
	localparam int CAUSE_EVENT = 7;

	// Reset values.
	localparam logic [31:0] WAKE_EN_RESET = 32'h0000_0000;
	localparam logic [15:0] DEBOUNCE_RESET = 16'h0000;
	localparam logic [7:0] PERIPH_EN_RESET = 8'h00;

	// Timing, in nanoseconds, and cycle counts derived from the clock.
	localparam int CLK_PERIOD_NS = 50;
	localparam int BACKUP_WAKE_MAX_NS = 500000;
	localparam int BACKUP_WAKE_MAX_CYC = BACKUP_WAKE_MAX_NS / CLK_PERIOD_NS;
	localparam int WAIT_WAKE_MAX_NS = 10000;
	localparam int WAIT_WAKE_MAX_CYC = WAIT_WAKE_MAX_NS / CLK_PERIOD_NS;
	localparam int REG_START_NS = 400000;
	localparam int REG_START_CYC =
		(REG_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RC_START_NS = 2000;
	localparam int RC_START_CYC =
		(RC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Power modes, including the two restart sequences.
	typedef enum logic [2:0] {
		MODE_ACTIVE = 3'b000,
		MODE_SLEEP = 3'b001,
		MODE_WAIT = 3'b010,
		MODE_BACKUP = 3'b011,
		MODE_BK_WAKE = 3'b100,
		MODE_WT_WAKE = 3'b101
	} lpms_mode_e;

	// Avalon-MM request from the master.
	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} lpms_avs_req_s;

	// Processor side: sleep instructions and wake causes.
	typedef struct packed {
		logic wait_for_event_instr;
		logic wait_for_interrupt_instr;
		logic deep_sleep_select;
		logic irq;
		logic event_in;
	} lpms_core_s;

	// Wake sources.
	typedef struct packed {
		logic force_wake_pin_b;
		logic [15:0] wake_pins;
		logic supply_monitor_alarm;
		logic rtc_alarm;
		logic tick_counter_alarm;
		logic usb_wake;
	} lpms_wake_s;

	// Clock and supply controls.
	typedef struct packed {
		logic regulator_shutdown_ctl;
		logic core_clk_en;
		logic mem_clk_en;
		logic [7:0] periph_clk_en;
		logic core_rst_b;
		logic io_pullup;
		logic [1:0] main_clk_src;
		logic keep_alive;
	} lpms_pwr_s;

	// Whole state of the sequencer.
	typedef struct packed {
		lpms_mode_e mode;
		logic entered_by_event;
		logic [15:0] timer;
		logic [15:0] force_cnt;
		logic [15:0] pin_cnt;
		logic [15:0] pin_ref;
		logic [15:0] pin_last;
		logic low_power_select_bit;
		logic [31:0] wake_en;
		logic [15:0] debounce;
		logic [1:0] clk_src;
		logic [7:0] periph_en;
		logic [7:0] cause;
		logic waitreq;
		logic [31:0] rdata;
		lpms_pwr_s pwr;
	} lpms_state_s;

endpackage

//--- verilog/lpms_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// (R1) Event wait with deep sleep set enters backup mode.
// (R2) Backup keeps supply control, reset, RTC, tick counter, 32 kHz running.
// (R3) Backup switches the regulator and core supply off.
// (R4) Debounced low on enabled force-wake pin leaves backup.
// (R5) Debounced enabled pin change, supply, RTC or tick alarm leaves backup.
// (R6) Backup wake runs a sequence restoring the core supply.
// (R7) Backup wake-up completes in under 0.5 ms.
// (R8) Wait mode stops core, peripheral and memory clocks, keeps supplies.
// (R9) Event wait with low-power bit set, deep sleep clear, enters wait.
// (R10) Software selects fast RC, sets low-power bit, then waits for event.
// (R11) Software should wait for the fast RC enable flag to clear.
// (R12) Wait is left on fast pins, RTC, tick counter or USB wake.
// (R13) Wait mode restarts in under 10 microseconds.
// (R14) Sleep stops only the core clock; peripheral clocks stay enabled.
// (R15) Either wait instruction with low-power bit clear enters sleep.
// (R16) Interrupt-entered sleep wakes on interrupt; event-entered on any event.
// (R17) Wait and backup wakes resume on the fast RC oscillator; sleep wake keeps the software clock source.
// (R18) Active clock source and peripheral clocks stay software adjustable.
// (R19) Backup wake restarts the core through reset; others resume unchanged.
// (R20) Regulator shutdown control low in backup, high otherwise.
module lpms_sequencer
	import lpms_pkg::*;
#(
	parameter int unsigned REG_START_CYC_P = REG_START_CYC,
	parameter int unsigned BACKUP_WAKE_MAX_CYC_P = BACKUP_WAKE_MAX_CYC
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Avalon-MM register slave.
	input wire lpms_avs_req_s avs_req_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Processor and wake sources.
	input wire lpms_core_s core_i,
	input wire lpms_wake_s wake_i,
	// Clock and supply controls.
	output lpms_pwr_s pwr_o
);

	// Merges write data into a register under the byte enables.
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	localparam logic [15:0] REG_LAST = 16'(REG_START_CYC_P - 1);
	localparam logic [15:0] RC_LAST = 16'(RC_START_CYC - 1);
	localparam logic [15:0] BK_MAX = 16'(BACKUP_WAKE_MAX_CYC_P);
	localparam logic [15:0] CNT_MAX = 16'hffff;

	lpms_state_s s;
	lpms_state_s next_s;

	logic [15:0] pin_chg;
	logic force_ok;
	logic pins_ok;
	logic backup_wake;
	logic fast_wake;
	logic sleep_wake;
	logic [7:0] wake_cause;
	logic [31:0] reg_word;

	// Reset image: running, regulator on, bus idle with waitrequest high.
	// Kept as constants so the asynchronous branch loads no logic.
	localparam lpms_pwr_s PWR_RESET = '{regulator_shutdown_ctl: 1'b1,
		core_clk_en: 1'b1, mem_clk_en: 1'b1,
		periph_clk_en: PERIPH_EN_RESET, core_rst_b: 1'b1, io_pullup: 1'b0,
		main_clk_src: CLK_SRC_RC, keep_alive: 1'b1};
	localparam lpms_state_s STATE_RESET = '{mode: MODE_ACTIVE,
		wake_en: WAKE_EN_RESET, debounce: DEBOUNCE_RESET,
		clk_src: CLK_SRC_RC, periph_en: PERIPH_EN_RESET, waitreq: 1'b1,
		pwr: PWR_RESET, default: '0};

	// Wake qualification. Pins and alarms are taken as synchronous, so a
	// pin needs one stable cycle before debounce counting even starts.
	always_comb begin
		pin_chg = (wake_i.wake_pins ^ s.pin_ref) & s.wake_en[15:0];
		// (R4) force-wake debounce
		force_ok = s.wake_en[WAKE_FORCE_BIT] && !wake_i.force_wake_pin_b &&
			(s.force_cnt >= s.debounce);
		// (R5) pin change debounce
		pins_ok = (pin_chg != 16'h0000) &&
			(wake_i.wake_pins == s.pin_last) && (s.pin_cnt >= s.debounce);
		// (R5) backup alarm sources
		backup_wake = force_ok || pins_ok ||
			(s.wake_en[WAKE_SUPPLY_BIT] && wake_i.supply_monitor_alarm) ||
			(s.wake_en[WAKE_RTC_BIT] && wake_i.rtc_alarm) ||
			(s.wake_en[WAKE_TICK_BIT] && wake_i.tick_counter_alarm);
		// (R12) fast start-up sources, pins active low
		fast_wake = ((~wake_i.wake_pins & s.wake_en[15:0]) != 16'h0000) ||
			(s.wake_en[WAKE_RTC_BIT] && wake_i.rtc_alarm) ||
			(s.wake_en[WAKE_TICK_BIT] && wake_i.tick_counter_alarm) ||
			(s.wake_en[WAKE_USB_BIT] && wake_i.usb_wake);
		// (R16) sleep exit depends on the entry instruction
		sleep_wake = core_i.irq ||
			(s.entered_by_event && (core_i.event_in || fast_wake));
		wake_cause = '0;
		wake_cause[CAUSE_FORCE] = force_ok;
		wake_cause[CAUSE_PINS] = pins_ok ||
			((~wake_i.wake_pins & s.wake_en[15:0]) != 16'h0000);
		wake_cause[CAUSE_SUPPLY] = wake_i.supply_monitor_alarm;
		wake_cause[CAUSE_RTC] = wake_i.rtc_alarm;
		wake_cause[CAUSE_TICK] = wake_i.tick_counter_alarm;
		wake_cause[CAUSE_USB] = wake_i.usb_wake;
		wake_cause[CAUSE_IRQ] = core_i.irq;
		wake_cause[CAUSE_EVENT] = core_i.event_in;
	end

	// Register read multiplexer; unmapped addresses read as zero.
	always_comb begin
		reg_word = '0;
		case (avs_req_i.address)
			ADDR_FSMR: reg_word[FSMR_LPS_BIT] = s.low_power_select_bit;
			ADDR_WAKE_EN: reg_word = s.wake_en;
			ADDR_DEBOUNCE: reg_word[15:0] = s.debounce;
			ADDR_CLK_CFG: begin
				reg_word[CLK_SRC_LSB +: 2] = s.clk_src;
				reg_word[PERIPH_EN_LSB +: 8] = s.periph_en;
			end
			ADDR_STATUS: begin
				reg_word[2:0] = s.mode;
				reg_word[STATUS_CAUSE_LSB +: 8] = s.cause;
			end
			default: reg_word = '0;
		endcase
	end

	// Next-state logic: bus slave, debounce counters, mode sequencer.
	always_comb begin
		logic [31:0] merged;
		merged = '0;
		next_s = s;
		next_s.pin_last = wake_i.wake_pins;

		// Every request is answered one cycle after it is seen.
		next_s.waitreq = 1'b1;
		if ((avs_req_i.read || avs_req_i.write) && s.waitreq) begin
			next_s.waitreq = 1'b0;
			next_s.rdata = avs_req_i.read ? reg_word : s.rdata;
		end
		if (avs_req_i.write && !s.waitreq) begin
			case (avs_req_i.address)
				ADDR_FSMR: begin
					merged = be_merge(32'(s.low_power_select_bit),
						avs_req_i.writedata, avs_req_i.byteenable);
					next_s.low_power_select_bit = merged[FSMR_LPS_BIT];
				end
				ADDR_WAKE_EN: begin
					next_s.wake_en = be_merge(s.wake_en,
						avs_req_i.writedata, avs_req_i.byteenable);
				end
				ADDR_DEBOUNCE: begin
					merged = be_merge({16'h0000, s.debounce},
						avs_req_i.writedata, avs_req_i.byteenable);
					next_s.debounce = merged[15:0];
				end
				// (R18) software sets clock source and peripheral clocks
				ADDR_CLK_CFG: begin
					merged = be_merge({16'h0000, s.periph_en, 6'h00,
						s.clk_src}, avs_req_i.writedata,
						avs_req_i.byteenable);
					next_s.clk_src = merged[CLK_SRC_LSB +: 2];
					next_s.periph_en = merged[PERIPH_EN_LSB +: 8];
				end
				default: next_s.rdata = s.rdata;
			endcase
		end

		// (R4) count while the force-wake pin is held low
		if (s.mode == MODE_BACKUP && !wake_i.force_wake_pin_b) begin
			next_s.force_cnt = (s.force_cnt == CNT_MAX) ? s.force_cnt :
				s.force_cnt + 16'h0001;
		end else begin
			next_s.force_cnt = '0;
		end
		// (R5) count while a changed pin pattern stays stable
		if (s.mode == MODE_BACKUP && pin_chg != 16'h0000 &&
			wake_i.wake_pins == s.pin_last) begin
			next_s.pin_cnt = (s.pin_cnt == CNT_MAX) ? s.pin_cnt :
				s.pin_cnt + 16'h0001;
		end else begin
			next_s.pin_cnt = '0;
		end

		case (s.mode)
			MODE_ACTIVE: begin
				if (core_i.wait_for_event_instr &&
					core_i.deep_sleep_select) begin
					// (R1) deep sleep entry
					next_s.mode = MODE_BACKUP;
					next_s.pin_ref = wake_i.wake_pins;
				end else if (core_i.wait_for_event_instr &&
					s.low_power_select_bit &&
					!core_i.wait_for_interrupt_instr) begin
					// (R9) wait entry
					next_s.mode = MODE_WAIT;
				end else if (core_i.wait_for_event_instr ||
					core_i.wait_for_interrupt_instr) begin
					// (R15) sleep entry
					next_s.mode = MODE_SLEEP;
					next_s.entered_by_event = core_i.wait_for_event_instr &&
						!core_i.wait_for_interrupt_instr;
				end
			end
			MODE_SLEEP: begin
				// (R16) sleep exit
				if (sleep_wake) begin
					next_s.mode = MODE_ACTIVE;
					next_s.cause = wake_cause;
				end
			end
			MODE_WAIT: begin
				// (R12) wait exit starts the fast RC
				if (fast_wake) begin
					next_s.mode = MODE_WT_WAKE;
					next_s.timer = '0;
					next_s.clk_src = CLK_SRC_RC;
					next_s.cause = wake_cause;
				end
			end
			MODE_WT_WAKE: begin
				// (R13) short oscillator restart
				next_s.timer = s.timer + 16'h0001;
				if (s.timer >= RC_LAST) begin
					next_s.mode = MODE_ACTIVE;
				end
			end
			MODE_BACKUP: begin
				// (R6) wake starts the supply restore sequence
				if (backup_wake) begin
					next_s.mode = MODE_BK_WAKE;
					next_s.timer = '0;
					next_s.clk_src = CLK_SRC_RC;
					next_s.cause = wake_cause;
				end
			end
			MODE_BK_WAKE: begin
				// (R7) regulator start-up time before core release
				next_s.timer = s.timer + 16'h0001;
				if (s.timer >= REG_LAST) begin
					next_s.mode = MODE_ACTIVE;
				end
			end
			default: next_s.mode = MODE_ACTIVE;
		endcase

		// Outputs follow the next mode so that they leave flip-flops.
		// (R3) regulator off only in backup
		next_s.pwr.regulator_shutdown_ctl = (next_s.mode != MODE_BACKUP);
		// (R8) core clock only while active
		next_s.pwr.core_clk_en = (next_s.mode == MODE_ACTIVE);
		// (R14) sleep keeps memory and peripheral clocks
		next_s.pwr.mem_clk_en = (next_s.mode == MODE_ACTIVE) ||
			(next_s.mode == MODE_SLEEP);
		next_s.pwr.periph_clk_en = next_s.pwr.mem_clk_en ?
			next_s.periph_en : 8'h00;
		// (R19) core held in reset until the supply is back
		next_s.pwr.core_rst_b = !((next_s.mode == MODE_BACKUP) ||
			(next_s.mode == MODE_BK_WAKE));
		next_s.pwr.io_pullup = !next_s.pwr.core_rst_b;
		// (R17) wake sequences force the fast RC source
		next_s.pwr.main_clk_src = next_s.clk_src;
		// (R2) always-on domain never stops
		next_s.pwr.keep_alive = 1'b1;
	end

	// The whole state registers here.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign avs_readdata_o = s.rdata;
	assign avs_waitrequest_o = s.waitreq;
	assign pwr_o = s.pwr;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// (R1) deep sleep entry
	AST_BACKUP_ENTRY: assert property ( // (R1)
		(s.mode == MODE_ACTIVE) && core_i.wait_for_event_instr &&
		core_i.deep_sleep_select |=> (s.mode == MODE_BACKUP) &&
		!pwr_o.core_clk_en)
		else $error("event wait with deep sleep did not reach backup");
	// (R2) always-on domain
	AST_KEEP_ALIVE: assert property ( // (R2)
		(s.mode == MODE_BACKUP) |-> pwr_o.keep_alive)
		else $error("always-on domain stopped in backup");
	// (R3) regulator off in backup
	AST_REG_OFF: assert property ( // (R3)
		(s.mode == MODE_BACKUP) |-> !pwr_o.regulator_shutdown_ctl &&
		!pwr_o.core_rst_b && pwr_o.io_pullup)
		else $error("regulator or core still on in backup");
	// (R4) immediate force wake without debounce
	AST_FORCE_WAKE: assert property ( // (R4)
		(s.mode == MODE_BACKUP) && s.wake_en[WAKE_FORCE_BIT] &&
		(s.debounce == 16'h0000) && !wake_i.force_wake_pin_b
		|=> (s.mode == MODE_BK_WAKE) && s.cause[CAUSE_FORCE])
		else $error("force wake pin ignored");
	// (R5) alarm wake from backup
	AST_ALARM_WAKE: assert property ( // (R5)
		(s.mode == MODE_BACKUP) && s.wake_en[WAKE_RTC_BIT] &&
		wake_i.rtc_alarm |=> (s.mode == MODE_BK_WAKE) &&
		pwr_o.regulator_shutdown_ctl)
		else $error("rtc alarm did not start backup wake");
	// (R6) supply restored during wake sequence with core in reset
	AST_BK_SEQ: assert property ( // (R6)
		(s.mode == MODE_BK_WAKE) |-> pwr_o.regulator_shutdown_ctl &&
		!pwr_o.core_rst_b && (pwr_o.main_clk_src == CLK_SRC_RC))
		else $error("backup wake sequence outputs wrong");
	// (R7) backup wake bound
	AST_BK_TIME: assert property ( // (R7)
		(s.mode == MODE_BK_WAKE) |-> (s.timer < BK_MAX))
		else $error("backup wake too slow");
	// (R8) wait mode clocks
	AST_WAIT_CLK: assert property ( // (R8)
		(s.mode == MODE_WAIT) |-> !pwr_o.core_clk_en &&
		!pwr_o.mem_clk_en && (pwr_o.periph_clk_en == 8'h00) &&
		pwr_o.regulator_shutdown_ctl && pwr_o.core_rst_b)
		else $error("wait mode clocks or supply wrong");
	// (R9) wait entry
	AST_WAIT_ENTRY: assert property ( // (R9)
		(s.mode == MODE_ACTIVE) && core_i.wait_for_event_instr &&
		!core_i.wait_for_interrupt_instr && !core_i.deep_sleep_select &&
		s.low_power_select_bit |=> (s.mode == MODE_WAIT))
		else $error("wait mode not entered");
	// (R12) wait exit on fast start-up source
	AST_WAIT_EXIT: assert property ( // (R12)
		(s.mode == MODE_WAIT) && s.wake_en[WAKE_USB_BIT] &&
		wake_i.usb_wake |=> (s.mode == MODE_WT_WAKE))
		else $error("usb wake did not leave wait");
	// (R13) restart within ten microseconds
	AST_WAIT_TIME: assert property ( // (R13)
		$rose(s.mode == MODE_WT_WAKE) |-> ##[1:200] pwr_o.core_clk_en)
		else $error("wait wake too slow");
	// (R14) sleep clocks
	AST_SLEEP_CLK: assert property ( // (R14)
		(s.mode == MODE_SLEEP) |-> !pwr_o.core_clk_en &&
		pwr_o.mem_clk_en && (pwr_o.periph_clk_en == s.periph_en))
		else $error("sleep clocks wrong");
	// (R15) sleep entry
	AST_SLEEP_ENTRY: assert property ( // (R15)
		(s.mode == MODE_ACTIVE) && core_i.wait_for_interrupt_instr &&
		!core_i.wait_for_event_instr |=> (s.mode == MODE_SLEEP) &&
		!s.entered_by_event)
		else $error("sleep not entered");
	// (R16) interrupt-entered sleep ignores events
	AST_SLEEP_HOLD: assert property ( // (R16)
		(s.mode == MODE_SLEEP) && !s.entered_by_event && !core_i.irq
		|=> (s.mode == MODE_SLEEP))
		else $error("sleep left without interrupt");
	// (R17) resume on fast RC
	AST_RC_RESUME: assert property ( // (R17)
		(s.mode == MODE_WT_WAKE) ##1 (s.mode == MODE_ACTIVE)
		|-> (pwr_o.main_clk_src == CLK_SRC_RC))
		else $error("wake did not resume on fast RC");
	// (R18) active mode follows software clock settings
	AST_ACTIVE_CFG: assert property ( // (R18)
		(s.mode == MODE_ACTIVE) && ($past(s.mode) == MODE_ACTIVE) |->
		(pwr_o.periph_clk_en == s.periph_en) &&
		(pwr_o.main_clk_src == s.clk_src))
		else $error("active clock settings not applied");
	// (R19) backup wake releases reset and the pull-up
	AST_RESET_RELEASE: assert property ( // (R19)
		(s.mode == MODE_BK_WAKE) ##1 (s.mode == MODE_ACTIVE) |->
		pwr_o.core_rst_b && !pwr_o.io_pullup && !$past(pwr_o.core_rst_b))
		else $error("core reset not released after backup wake");
	// (R20) regulator high outside backup
	AST_REG_ON: assert property ( // (R20)
		(s.mode != MODE_BACKUP) |-> pwr_o.regulator_shutdown_ctl)
		else $error("regulator off outside backup");

endmodule
